// File: src/rank_decode_map.svh
// Register offsets, field positions and reset values of the rank decode block.
`ifndef RANK_DECODE_MAP_SVH
`define RANK_DECODE_MAP_SVH

// ****************************************************************
// Register offsets within the controller window
// ****************************************************************
`define OFF_CHANNEL_DECODE_MISC_CONFIG 12'h111
`define OFF_CH0_RANK0_UPPER_BOUND 12'h200
`define OFF_CH0_RANK1_UPPER_BOUND 12'h202
`define OFF_CH1_RANK0_UPPER_BOUND 12'h600
`define OFF_CH1_RANK1_UPPER_BOUND 12'h602

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define BOUND_MSB 9
`define BOUND_WIDTH 10
`define MISC_SWAP_MSB 6
`define MISC_SWAP_LSB 5
`define MISC_CH1_ENH_BIT 3
`define MISC_CH0_ENH_BIT 2
`define MISC_FLEX_BIT 1
`define MISC_WMASK 8'h6E
`define MISC_RESET 8'h00
`define BOUND_RESET 10'h000
`define UNIT_SHIFT 26
`define ADDR_WIDTH 36

`endif

// File: src/rank_decode_pkg.sv
// Types shared by the rank decode block.
package rank_decode_pkg;

  // ****************************************************************
  // Swap mode encodings and carried groups
  // ****************************************************************
  typedef enum logic [1:0] {
    SWAP_BANK_AND_RANK = 2'b00,
    SWAP_RSVD_01 = 2'b01,
    SWAP_BANK_ONLY = 2'b10,
    SWAP_RSVD_11 = 2'b11
  } swap_mode_t;

  typedef struct packed {
    swap_mode_t select_swap_mode;
    logic second_channel_enhanced_addr;
    logic first_channel_enhanced_addr;
    logic asymmetric_interleave_enable;
  } misc_cfg_t;

  typedef struct packed {
    logic [1:0] ch0_cs;
    logic [1:0] ch1_cs;
  } rank_select_t;

endpackage : rank_decode_pkg

// File: src/rank_bound_compare.sv
// One channel's rank decode: picks the lowest rank whose bound lies above the address.
`timescale 1ns/1ps
`include "rank_decode_map.svh"

module rank_bound_compare (
  input wire logic [`BOUND_WIDTH-1:0] i_bound0,
  input wire logic [`BOUND_WIDTH-1:0] i_bound1,
  input wire logic [`ADDR_WIDTH-`UNIT_SHIFT-1:0] i_unit,
  output logic [1:0] o_cs
);

  // Strict compare: an address equal to a bound belongs to the next rank up.
  wire logic below0 = i_unit < i_bound0; // RL2
  wire logic below1 = i_unit < i_bound1;
  assign o_cs = below0 ? 2'b01 : (below1 ? 2'b10 : 2'b00); // RL11

endmodule : rank_bound_compare

// File: src/rank_channel_decode.sv
// Register file and two-channel rank chip select decode.
// Summary of operation
// RL1: One ten-bit upper bound per rank is kept, counted in 64 MB units.
// RL2: Each incoming address is compared against the bounds to pick the rank chip select.
// RL3: Bound registers hold a writable field in bits 9:0, bits 15:10 read zero and reset zero.
// RL4: Software writes bounds cumulatively, rank 1 holding the sum of rank 0 and rank 1 sizes.
// RL5: Software writes zero to all bounds of an empty channel.
// RL6: In flex mode software writes the top channel 1 bounds as channel 1 plus channel 0 totals.
// RL7: Bits 6:5 select the swap mode, 00 bank and rank, 10 bank only, others reserved.
// RL8: Bit 3 enables enhanced addressing for channel 1, reset zero.
// RL9: Bit 2 enables enhanced addressing for channel 0, reset zero.
// RL10: Bit 1 enables flex memory, reset zero, bits 7, 4 and 0 reserved.
// RL11: The lowest rank whose bound exceeds the address unit wins; above all bounds none is chosen.
`timescale 1ns/1ps
`include "rank_decode_map.svh"

module rank_channel_decode (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [11:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [1:0] i_reg_be,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_mem_valid,
  input wire logic i_mem_chan,
  input wire logic [`ADDR_WIDTH-1:0] i_mem_addr,
  output rank_decode_pkg::rank_select_t o_rank_cs,
  output logic o_cs_valid,
  output rank_decode_pkg::misc_cfg_t o_misc_cfg
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Registers are word aligned here; the odd misc offset is a byte register.
  wire logic hit_misc = i_reg_addr == `OFF_CHANNEL_DECODE_MISC_CONFIG;
  wire logic hit_c0r0 = i_reg_addr == `OFF_CH0_RANK0_UPPER_BOUND;
  wire logic hit_c0r1 = i_reg_addr == `OFF_CH0_RANK1_UPPER_BOUND;
  wire logic hit_c1r0 = i_reg_addr == `OFF_CH1_RANK0_UPPER_BOUND;
  wire logic hit_c1r1 = i_reg_addr == `OFF_CH1_RANK1_UPPER_BOUND;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] misc_q;
  logic [7:0] misc_d;
  logic [`BOUND_WIDTH-1:0] c0r0_q;
  logic [`BOUND_WIDTH-1:0] c0r0_d;
  logic [`BOUND_WIDTH-1:0] c0r1_q;
  logic [`BOUND_WIDTH-1:0] c0r1_d;
  logic [`BOUND_WIDTH-1:0] c1r0_q;
  logic [`BOUND_WIDTH-1:0] c1r0_d;
  logic [`BOUND_WIDTH-1:0] c1r1_q;
  logic [`BOUND_WIDTH-1:0] c1r1_d;

  // ****************************************************************
  // Byte lane write enables
  // ****************************************************************
  // One enable per lane, so a partial write never disturbs the other byte.
  wire logic wr_lo = i_reg_wr && i_reg_be[0];
  wire logic wr_hi = i_reg_wr && i_reg_be[1];
  wire logic we_misc = hit_misc && wr_lo;
  wire logic we_c0r0_lo = hit_c0r0 && wr_lo;
  wire logic we_c0r0_hi = hit_c0r0 && wr_hi;
  wire logic we_c0r1_lo = hit_c0r1 && wr_lo;
  wire logic we_c0r1_hi = hit_c0r1 && wr_hi;
  wire logic we_c1r0_lo = hit_c1r0 && wr_lo;
  wire logic we_c1r0_hi = hit_c1r0 && wr_hi;
  wire logic we_c1r1_lo = hit_c1r1 && wr_lo;
  wire logic we_c1r1_hi = hit_c1r1 && wr_hi;

  // ****************************************************************
  // Next register values
  // ****************************************************************
  // Misc writes keep reserved bits 7, 4 and 0 at zero; the high lane is ignored.
  assign misc_d = we_misc ? (i_reg_wdata[7:0] & `MISC_WMASK) : misc_q; // RL10

  // Low lane carries bound bits 7:0 and high lane bits 9:8; bits 15:10 are never stored.
  assign c0r0_d = {(we_c0r0_hi ? i_reg_wdata[`BOUND_MSB:8] : c0r0_q[`BOUND_MSB:8]),
                   (we_c0r0_lo ? i_reg_wdata[7:0] : c0r0_q[7:0])}; // RL1 RL3

  // Channel 0 rank 1 bound, same lane split.
  assign c0r1_d = {(we_c0r1_hi ? i_reg_wdata[`BOUND_MSB:8] : c0r1_q[`BOUND_MSB:8]),
                   (we_c0r1_lo ? i_reg_wdata[7:0] : c0r1_q[7:0])}; // RL1 RL3

  // Channel 1 rank 0 bound, same lane split.
  assign c1r0_d = {(we_c1r0_hi ? i_reg_wdata[`BOUND_MSB:8] : c1r0_q[`BOUND_MSB:8]),
                   (we_c1r0_lo ? i_reg_wdata[7:0] : c1r0_q[7:0])}; // RL1 RL3

  // Channel 1 rank 1 bound, same lane split.
  assign c1r1_d = {(we_c1r1_hi ? i_reg_wdata[`BOUND_MSB:8] : c1r1_q[`BOUND_MSB:8]),
                   (we_c1r1_lo ? i_reg_wdata[7:0] : c1r1_q[7:0])}; // RL1 RL3

  // Misc clears to zero, so enhanced and flex modes start off.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      misc_q <= `MISC_RESET; // RL8 RL9 RL10
    end else begin
      misc_q <= misc_d;
    end
  end

  // A zero bound means the rank holds no memory, which is the safe state after reset.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      c0r0_q <= `BOUND_RESET; // RL3
    end else begin
      c0r0_q <= c0r0_d;
    end
  end

  // Channel 0 rank 1 bound register.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      c0r1_q <= `BOUND_RESET; // RL3
    end else begin
      c0r1_q <= c0r1_d;
    end
  end

  // Channel 1 rank 0 bound register.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      c1r0_q <= `BOUND_RESET; // RL3
    end else begin
      c1r0_q <= c1r0_d;
    end
  end

  // Channel 1 rank 1 bound register.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      c1r1_q <= `BOUND_RESET; // RL3
    end else begin
      c1r1_q <= c1r1_d;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Reserved bits are zero-filled here, so bits 15:10 of a bound always read zero.
  wire logic [15:0] rb_misc = {8'h00, misc_q};
  wire logic [15:0] rb_c0r0 = {6'h00, c0r0_q}; // RL3
  wire logic [15:0] rb_c0r1 = {6'h00, c0r1_q}; // RL3
  wire logic [15:0] rb_c1r0 = {6'h00, c1r0_q}; // RL3
  wire logic [15:0] rb_c1r1 = {6'h00, c1r1_q}; // RL3

  // Unmapped offsets read zero.
  wire logic [15:0] rd_mux =
    hit_misc ? rb_misc :
    hit_c0r0 ? rb_c0r0 :
    hit_c0r1 ? rb_c0r1 :
    hit_c1r0 ? rb_c1r0 :
    hit_c1r1 ? rb_c1r1 : 16'h0000;

  // Read data hold until the next read, so a slow master may pick them up late.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 16'h0000;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_mux : o_reg_rdata;
    end
  end

  // The valid flag marks the one cycle in which fresh read data stand.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
    end
  end

  // ****************************************************************
  // Mode outputs
  // ****************************************************************
  // The swap field is passed as stored; reserved codes are not filtered.
  assign o_misc_cfg.select_swap_mode =
    rank_decode_pkg::swap_mode_t'(misc_q[`MISC_SWAP_MSB:`MISC_SWAP_LSB]); // RL7
  assign o_misc_cfg.second_channel_enhanced_addr = misc_q[`MISC_CH1_ENH_BIT]; // RL8
  assign o_misc_cfg.first_channel_enhanced_addr = misc_q[`MISC_CH0_ENH_BIT]; // RL9
  assign o_misc_cfg.asymmetric_interleave_enable = misc_q[`MISC_FLEX_BIT]; // RL10

  // ****************************************************************
  // Rank decode
  // ****************************************************************
  // Flex mode changes only how software programs channel 1 bounds, not the compare.
  // Only two ranks per channel are built; an address above rank 1's bound selects none.
  wire logic [`ADDR_WIDTH-`UNIT_SHIFT-1:0] addr_unit = i_mem_addr[`ADDR_WIDTH-1:`UNIT_SHIFT];
  logic [1:0] cs0;
  logic [1:0] cs1;

  rank_bound_compare u_ch0 (
    .i_bound0(c0r0_q),
    .i_bound1(c0r1_q),
    .i_unit(addr_unit),
    .o_cs(cs0)
  );

  rank_bound_compare u_ch1 (
    .i_bound0(c1r0_q),
    .i_bound1(c1r1_q),
    .i_unit(addr_unit),
    .o_cs(cs1)
  );

  // A request steers only the selects of its own channel; the other stays quiet.
  wire logic take_ch0 = i_mem_valid && !i_mem_chan;
  wire logic take_ch1 = i_mem_valid && i_mem_chan;

  // Chip selects are registered so the pins see a clean one-cycle-late decode.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rank_cs <= '0;
      o_cs_valid <= 1'b0;
    end else begin
      o_rank_cs.ch0_cs <= take_ch0 ? cs0 : 2'b00; // RL2 RL11
      o_rank_cs.ch1_cs <= take_ch1 ? cs1 : 2'b00; // RL2 RL11
      o_cs_valid <= i_mem_valid;
    end
  end

endmodule : rank_channel_decode

// File: tb/rank_channel_decode_chk.sv
// Port checker for the rank decode block.
`timescale 1ns/1ps
`include "rank_decode_map.svh"
module rank_channel_decode_chk (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [11:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [1:0] i_reg_be,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_mem_valid,
  input wire logic i_mem_chan,
  input wire logic [`ADDR_WIDTH-1:0] i_mem_addr,
  input wire rank_decode_pkg::rank_select_t o_rank_cs,
  input wire logic o_cs_valid,
  input wire rank_decode_pkg::misc_cfg_t o_misc_cfg
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // A misc write with the low lane enabled; bits above the low byte never reach the field.
  sequence misc_wr_s;
    i_reg_wr && i_reg_be[0] && i_reg_addr == `OFF_CHANNEL_DECODE_MISC_CONFIG;
  endsequence
  // A misc read returns the stored fields with reserved bits at zero.
  sequence misc_rd_s;
    i_reg_rd && i_reg_addr == `OFF_CHANNEL_DECODE_MISC_CONFIG;
  endsequence
  misc_rsvd_a: assert property (
    misc_rd_s |=> o_reg_rdata[15:7] == 9'h000 && o_reg_rdata[4] == 1'b0
      && o_reg_rdata[0] == 1'b0)
    else $error("misc read shows a reserved bit set");
  misc_echo_a: assert property (
    misc_rd_s |=> o_reg_rdata[6:1] == {$past(o_misc_cfg[4:3]), 1'b0, $past(o_misc_cfg[2:0])})
    else $error("misc read disagrees with the exported fields");
  rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid && o_reg_rdata[15:10] == 6'h00)
    else $error("read answer missing or reserved bits set");
  rd_quiet_a: assert property (!i_reg_rd |=> !o_reg_rvalid)
    else $error("read valid without a read");
  misc_load_a: assert property (
    misc_wr_s |=> o_misc_cfg == {$past(i_reg_wdata[6:5]), $past(i_reg_wdata[3:1])})
    else $error("misc fields not loaded from write data");
  misc_hold_a: assert property (!i_reg_wr |=> $stable(o_misc_cfg))
    else $error("misc fields changed without a write");
  cs_follow_a: assert property (1'b1 |=> o_cs_valid == $past(i_mem_valid))
    else $error("select valid does not follow request");
  cs_onehot_a: assert property (o_cs_valid |-> $onehot0(o_rank_cs))
    else $error("more than one rank selected");
  ch0_only_a: assert property (i_mem_valid && !i_mem_chan |=> o_rank_cs.ch1_cs == 2'b00)
    else $error("channel 1 selected for channel 0 access");
  ch1_only_a: assert property (i_mem_valid && i_mem_chan |=> o_rank_cs.ch0_cs == 2'b00)
    else $error("channel 0 selected for channel 1 access");
  idle_cs_a: assert property (!i_mem_valid |=> o_rank_cs == 4'h0)
    else $error("rank selected without a request");
endmodule : rank_channel_decode_chk

// File: tb/rank_set_model.sv
// Behavioural rank set that counts chip select pulses per rank.
`timescale 1ns/1ps
module rank_set_model (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_cs_valid,
  input wire rank_decode_pkg::rank_select_t i_rank_cs,
  output logic [3:0][7:0] o_hits
);
  // Each rank counts the accesses it answered; a stray select shows as an extra hit.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) o_hits <= '0;
    else if (i_cs_valid) for (int i = 0; i < 4; i++) o_hits[i] <= o_hits[i] + 8'(i_rank_cs[i]);
  end
endmodule : rank_set_model

// File: tb/rank_channel_decode_tb_top.sv
// Self-checking bench for the rank decode block.
`timescale 1ns/1ps
`include "rank_decode_map.svh"
module rank_channel_decode_tb_top;
  logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic i_mem_valid = 1'b0, i_mem_chan = 1'b0, o_reg_rvalid, o_cs_valid;
  logic [11:0] i_reg_addr = 12'h000;
  logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
  logic [1:0] i_reg_be = 2'h0;
  logic [`ADDR_WIDTH-1:0] i_mem_addr = '0;
  rank_decode_pkg::rank_select_t o_rank_cs;
  rank_decode_pkg::misc_cfg_t o_misc_cfg;
  logic [3:0][7:0] hits;
  logic [11:0] offs [5] = '{12'h111, 12'h200, 12'h202, 12'h600, 12'h602};
  logic [9:0] du [6] = '{10'h000, 10'h002, 10'h003, 10'h004, 10'h005, 10'h009};
  logic [3:0] de [6] = '{4'h4, 4'h4, 4'h8, 4'h8, 4'h0, 4'h0};
  int error_cnt = 0;
  int n_checks = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  rank_channel_decode u_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_be(i_reg_be),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_mem_valid(i_mem_valid),
    .i_mem_chan(i_mem_chan), .i_mem_addr(i_mem_addr), .o_rank_cs(o_rank_cs),
    .o_cs_valid(o_cs_valid), .o_misc_cfg(o_misc_cfg));
  rank_set_model u_ranks (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_cs_valid(o_cs_valid),
    .i_rank_cs(o_rank_cs), .o_hits(hits));
  task automatic print_verdict;
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_cs(input logic [3:0] e, input logic [3:0] g, input logic v);
    n_checks++;
    if (g !== e || v !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED rank_cs expected %h seen %h valid %b", e, g, v);
    end
  endtask : chk_cs
  // Strobes rise at one edge and fall at the next, so calls never collide.
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_be <= be;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1;
    chk_reg("rvalid", 16'h0001, {15'h0000, o_reg_rvalid});
    chk_reg("rdata", e, o_reg_rdata);
  endtask : rd
  // Low address bits are all ones so only the 64 MB unit may steer the choice.
  task automatic dec(input logic c, input logic [9:0] u, input logic [3:0] e);
    @(posedge i_clk_sys);
    i_mem_valid <= 1'b1;
    i_mem_chan <= c;
    i_mem_addr <= {u, 26'h3FFFFFF};
    @(posedge i_clk_sys);
    i_mem_valid <= 1'b0;
    #1;
    chk_cs(e, o_rank_cs, o_cs_valid);
  endtask : dec
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
  // Main sequence: reset values, field access, then decode across boundaries.
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    foreach (offs[i]) rd(offs[i], 16'h0000);
    wr(12'h204, 16'h03FF, 2'b11);
    rd(12'h204, 16'h0000);
    wr(`OFF_CH0_RANK0_UPPER_BOUND, 16'hFC03, 2'b11);
    rd(`OFF_CH0_RANK0_UPPER_BOUND, 16'h0003);
    wr(`OFF_CH0_RANK1_UPPER_BOUND, 16'hAA05, 2'b01);
    wr(`OFF_CH0_RANK1_UPPER_BOUND, 16'hFC00, 2'b10);
    rd(`OFF_CH0_RANK1_UPPER_BOUND, 16'h0005);
    wr(`OFF_CHANNEL_DECODE_MISC_CONFIG, 16'hFFFF, 2'b01);
    rd(`OFF_CHANNEL_DECODE_MISC_CONFIG, 16'h006E);
    chk_reg("misc_cfg", 16'h001F, {11'h000, o_misc_cfg});
    for (int s = 0; s < 4; s++) begin
      wr(`OFF_CHANNEL_DECODE_MISC_CONFIG, 16'(s << 5), 2'b01);
      #1;
      chk_reg("swap_mode", 16'(s << 3), {11'h000, o_misc_cfg});
    end
    wr(`OFF_CHANNEL_DECODE_MISC_CONFIG, 16'h0008, 2'b01);
    #1;
    chk_reg("ch1_enh", 16'h0004, {11'h000, o_misc_cfg});
    wr(`OFF_CHANNEL_DECODE_MISC_CONFIG, 16'h0004, 2'b01);
    #1;
    chk_reg("ch0_enh", 16'h0002, {11'h000, o_misc_cfg});
    foreach (du[i]) dec(1'b0, du[i], de[i]);
    dec(1'b1, 10'h000, 4'h0);
    wr(`OFF_CHANNEL_DECODE_MISC_CONFIG, 16'h0002, 2'b01);
    #1;
    chk_reg("flex", 16'h0001, {11'h000, o_misc_cfg});
    wr(`OFF_CHANNEL_DECODE_MISC_CONFIG, 16'h00FF, 2'b10);
    #1;
    chk_reg("flex_hi_lane", 16'h0001, {11'h000, o_misc_cfg});
    wr(`OFF_CH1_RANK0_UPPER_BOUND, 16'h0002, 2'b11);
    wr(`OFF_CH1_RANK1_UPPER_BOUND, 16'h0009, 2'b11);
    dec(1'b1, 10'h001, 4'h1);
    dec(1'b1, 10'h008, 4'h2);
    dec(1'b1, 10'h009, 4'h0);
    chk_reg("rank_hits", 16'h0202, {hits[3], hits[2]});
    chk_reg("rank_hits", 16'h0101, {hits[1], hits[0]});
    wr(`OFF_CH1_RANK1_UPPER_BOUND, 16'hFF00, 2'b10);
    rd(`OFF_CH1_RANK1_UPPER_BOUND, 16'h0309);
    // A second reset in mid-run must bring misc and the channel 1 bounds back to zero.
    @(posedge i_clk_sys);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rd(`OFF_CHANNEL_DECODE_MISC_CONFIG, 16'h0000);
    rd(`OFF_CH1_RANK1_UPPER_BOUND, 16'h0000);
    dec(1'b1, 10'h001, 4'h0);
    print_verdict();
  end
endmodule : rank_channel_decode_tb_top
bind rank_channel_decode rank_channel_decode_chk u_chk (.i_clk_sys(i_clk_sys),
  .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_be(i_reg_be), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .i_mem_valid(i_mem_valid), .i_mem_chan(i_mem_chan),
  .i_mem_addr(i_mem_addr), .o_rank_cs(o_rank_cs), .o_cs_valid(o_cs_valid),
  .o_misc_cfg(o_misc_cfg));
